//--- design/cbrp_pkg.sv
// ****************************************************************
// shared constants for bit-rate and transmit-priority block
// ****************************************************************
package cbrp_pkg;
  // apb register byte offsets
  localparam logic [7:0] CBRP_OFS_GCFG = 8'h00;
  localparam logic [7:0] CBRP_OFS_CTRL = 8'h04;
  localparam logic [7:0] CBRP_OFS_NBT = 8'h08;
  localparam logic [7:0] CBRP_OFS_DBT = 8'h0C;
  localparam logic [7:0] CBRP_OFS_STAT = 8'h10;
  // global configuration fields
  localparam int CBRP_GCFG_PRIO_BIT = 0;
  localparam int CBRP_GCFG_CSRC_BIT = 1;
  // control fields
  localparam int CBRP_CTRL_CFG_BIT = 0;
  // bit timing field positions and widths (nominal and data share layout)
  localparam int CBRP_BRP_LSB = 0;
  localparam int CBRP_BRP_W = 10;
  localparam int CBRP_TS1_LSB = 10;
  localparam int CBRP_TS1_W = 8;
  localparam int CBRP_TS2_LSB = 18;
  localparam int CBRP_TS2_W = 7;
  localparam int CBRP_SJW_LSB = 25;
  localparam int CBRP_SJW_W = 7;
  // reset values
  localparam logic [31:0] CBRP_GCFG_RST = 32'h0000_0000;
  localparam logic [31:0] CBRP_CTRL_RST = 32'h0000_0001;
  localparam logic [31:0] CBRP_NBT_RST = 32'h020C_1004;
  localparam logic [31:0] CBRP_DBT_RST = 32'h020C_1001;
  // identifier width and arbitration key width
  localparam int CBRP_ID_W = 29;
  localparam int CBRP_ARB_W = 31;
  // winner source kinds
  localparam logic [1:0] CBRP_KIND_BUF = 2'h0;
  localparam logic [1:0] CBRP_KIND_FIFO = 2'h1;
  localparam logic [1:0] CBRP_KIND_QUEUE = 2'h2;
  // arbiter states
  typedef enum logic [1:0] {CBRP_SEL, CBRP_RDY, CBRP_BUSY} cbrp_arb_t;
endpackage : cbrp_pkg

//--- design/cbrp_bit_timer.sv
`timescale 1ns/1ps
// ****************************************************************
// prescaler and quanta counter building one bit
// ****************************************************************
module cbrp_bit_timer
  import cbrp_pkg::*;
(
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset,
  // control
  input wire logic i_run,
  input wire logic i_core_tick,
  input wire logic i_data_phase,
  // nominal and data settings
  input wire logic [CBRP_BRP_W-1:0] i_nom_brp,
  input wire logic [CBRP_TS1_W-1:0] i_nom_ts1,
  input wire logic [CBRP_TS2_W-1:0] i_nom_ts2,
  input wire logic [CBRP_BRP_W-1:0] i_dat_brp,
  input wire logic [CBRP_TS1_W-1:0] i_dat_ts1,
  input wire logic [CBRP_TS2_W-1:0] i_dat_ts2,
  // timing strobes
  output logic o_tq_tick,
  output logic o_sample,
  output logic o_bit_end
);
  localparam int QW = 9;
  logic [CBRP_BRP_W-1:0] cur_brp;
  logic [CBRP_TS1_W-1:0] cur_ts1;
  logic [CBRP_TS2_W-1:0] cur_ts2;
  logic [CBRP_BRP_W-1:0] pcnt;
  logic [QW-1:0] qcnt;
  logic [QW-1:0] bit_len;
  logic tq_now;
  logic bit_now;
  logic [CBRP_BRP_W-1:0] chk_core;

  // zero division value behaves as one
  function automatic logic [CBRP_BRP_W-1:0] eff_brp(input logic [CBRP_BRP_W-1:0] v);
    eff_brp = (v == '0) ? {{(CBRP_BRP_W-1){1'b0}}, 1'b1} : v;
  endfunction : eff_brp

  // sync quantum plus both segments
  assign bit_len = QW'(1) + QW'(cur_ts1) + QW'(cur_ts2);
  assign tq_now = i_core_tick && (pcnt == cur_brp - 1'b1);
  assign bit_now = tq_now && (qcnt == bit_len - 1'b1);

  // active settings change only at a bit boundary or while not running
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      cur_brp <= 10'h001;
      cur_ts1 <= 8'h01;
      cur_ts2 <= 7'h01;
    end else if (!i_run || bit_now) begin
      cur_brp <= i_data_phase ? eff_brp(i_dat_brp) : eff_brp(i_nom_brp);
      cur_ts1 <= i_data_phase ? i_dat_ts1 : i_nom_ts1;
      cur_ts2 <= i_data_phase ? i_dat_ts2 : i_nom_ts2;
    end
  end

  // prescaler over core clock ticks
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      pcnt <= '0;
    end else if (!i_run || tq_now) begin
      pcnt <= '0;
    end else if (i_core_tick) begin
      pcnt <= pcnt + 1'b1;
    end
  end

  // quanta within the bit
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      qcnt <= '0;
    end else if (!i_run || bit_now) begin
      qcnt <= '0;
    end else if (tq_now) begin
      qcnt <= qcnt + 1'b1;
    end
  end

  // registered strobes
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      o_tq_tick <= 1'b0;
      o_sample <= 1'b0;
      o_bit_end <= 1'b0;
    end else begin
      o_tq_tick <= i_run && tq_now;
      o_sample <= i_run && tq_now && (qcnt == QW'(cur_ts1));
      o_bit_end <= i_run && bit_now;
    end
  end

  // helper: core ticks seen since the last quantum
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      chk_core <= '0;
    end else if (!i_run || tq_now) begin
      chk_core <= '0;
    end else if (i_core_tick) begin
      chk_core <= chk_core + 1'b1;
    end
  end

  a_tq_prescale: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (i_run && tq_now) |-> (i_core_tick && chk_core == cur_brp - 1'b1))
    else $error("quantum not at prescaler count");
  a_sample_pos: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    o_sample |-> $past(qcnt) == QW'($past(cur_ts1)))
    else $error("sample point not after sync and first segment");
  a_bit_length: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    o_bit_end |-> $past(qcnt) == $past(bit_len) - 1'b1)
    else $error("bit length not sync plus two segments");
endmodule : cbrp_bit_timer

//--- design/cbrp_top.sv
// Contract
// - bit rate is core clock over prescaler times quanta
// - core clock chosen from peripheral or oscillator
// - separate nominal and data phase settings
// - nominal prescaler takes any division value
// - sync plus two segments, sample after first
// - one priority method for all channels
// - identifier priority follows bus arbitration order
// - buffers and transmit FIFOs compete, queues too under identifier priority
// - FIFO oldest competes, next while sending
// - every queue entry competes under identifier priority
// - equal identifier, lower buffer number wins
// - buffer mode: lowest pending buffer first
// - linked FIFO uses its buffer number
// - reselect after arbitration loss or error
// - bit split into three segments
`timescale 1ns/1ps
module cbrp_top
  import cbrp_pkg::*;
#(
  parameter int NBUF = 4,
  parameter int NFIFO = 2,
  parameter int NQ = 4,
  parameter int BNUM_W = 7
)(
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // core clock sources as ticks and phase select
  input wire logic i_periph_tick,
  input wire logic i_xosc_tick,
  input wire logic i_data_phase,
  // bit timing strobes
  output logic o_tq_tick,
  output logic o_sample,
  output logic o_bit_end,
  // transmit buffers
  input wire logic [NBUF-1:0] i_buf_pend,
  input wire logic [NBUF*CBRP_ID_W-1:0] i_buf_id,
  input wire logic [NBUF-1:0] i_buf_ext,
  // shared FIFOs
  input wire logic [NFIFO-1:0] i_fifo_txmode,
  input wire logic [NFIFO-1:0] i_fifo_busy,
  input wire logic [NFIFO*BNUM_W-1:0] i_fifo_link,
  input wire logic [NFIFO-1:0] i_fifo_head_pend,
  input wire logic [NFIFO*CBRP_ID_W-1:0] i_fifo_head_id,
  input wire logic [NFIFO-1:0] i_fifo_head_ext,
  input wire logic [NFIFO-1:0] i_fifo_next_pend,
  input wire logic [NFIFO*CBRP_ID_W-1:0] i_fifo_next_id,
  input wire logic [NFIFO-1:0] i_fifo_next_ext,
  // transmit queue entries
  input wire logic [NQ-1:0] i_q_pend,
  input wire logic [NQ*CBRP_ID_W-1:0] i_q_id,
  input wire logic [NQ-1:0] i_q_ext,
  input wire logic [NQ*BNUM_W-1:0] i_q_num,
  // frame progress from the protocol engine
  input wire logic i_tx_start,
  input wire logic i_tx_done,
  input wire logic i_arb_lost,
  input wire logic i_tx_error,
  // selected frame
  output logic o_sel_valid,
  output logic [1:0] o_sel_kind,
  output logic [7:0] o_sel_index,
  output logic [BNUM_W-1:0] o_sel_num,
  output logic [CBRP_ID_W-1:0] o_sel_id,
  output logic o_sel_ext
);
  localparam int KEY_W = CBRP_ARB_W + BNUM_W;

  // ****************************************************************
  // registers and apb slave
  // ****************************************************************
  logic [31:0] gcfg;
  logic [31:0] ctrl;
  logic [31:0] nbt;
  logic [31:0] dbt;
  logic cfg_mode;
  logic prio_bufnum;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic addr_locked;
  logic [31:0] next_rdata;
  cbrp_arb_t state;

  assign cfg_mode = ctrl[CBRP_CTRL_CFG_BIT];
  assign prio_bufnum = gcfg[CBRP_GCFG_PRIO_BIT];
  assign wr_en = i_psel && i_penable && i_pwrite && !o_pready;
  assign rd_en = i_psel && i_penable && !i_pwrite && !o_pready;
  assign addr_ok = (i_paddr == CBRP_OFS_GCFG) || (i_paddr == CBRP_OFS_CTRL) ||
                   (i_paddr == CBRP_OFS_NBT) || (i_paddr == CBRP_OFS_DBT) ||
                   (i_paddr == CBRP_OFS_STAT);
  // global and timing settings locked outside configuration, status read only
  assign addr_locked = (i_paddr == CBRP_OFS_STAT) || (!cfg_mode &&
                       (i_paddr != CBRP_OFS_CTRL));

  // read data mux
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (i_paddr)
      CBRP_OFS_GCFG: next_rdata = gcfg;
      CBRP_OFS_CTRL: next_rdata = ctrl;
      CBRP_OFS_NBT: next_rdata = nbt;
      CBRP_OFS_DBT: next_rdata = dbt;
      CBRP_OFS_STAT: next_rdata = {14'h0000, o_sel_num, 7'h00, state, o_sel_valid, cfg_mode};
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // one wait state: answer in the second access cycle
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h0000_0000;
    end else begin
      o_pready <= i_psel && i_penable && !o_pready;
      o_pslverr <= (wr_en && (!addr_ok || addr_locked)) || (rd_en && !addr_ok);
      o_prdata <= rd_en ? next_rdata : 32'h0000_0000;
    end
  end

  // register writes
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      gcfg <= CBRP_GCFG_RST;
      ctrl <= CBRP_CTRL_RST;
      nbt <= CBRP_NBT_RST;
      dbt <= CBRP_DBT_RST;
    end else if (wr_en && addr_ok && !addr_locked) begin
      case (i_paddr)
        CBRP_OFS_GCFG: gcfg <= i_pwdata & 32'h0000_0003;
        CBRP_OFS_CTRL: ctrl <= i_pwdata & 32'h0000_0001;
        CBRP_OFS_NBT: nbt <= i_pwdata;
        CBRP_OFS_DBT: dbt <= i_pwdata;
        default: ctrl <= ctrl;
      endcase
    end
  end

  // ****************************************************************
  // bit timing
  // ****************************************************************
  logic core_tick;

  assign core_tick = gcfg[CBRP_GCFG_CSRC_BIT] ? i_xosc_tick : i_periph_tick;

  cbrp_bit_timer u_timer (
    .i_ref_clk(i_ref_clk),
    .i_reset(i_reset),
    .i_run(!cfg_mode),
    .i_core_tick(core_tick),
    .i_data_phase(i_data_phase),
    .i_nom_brp(nbt[CBRP_BRP_LSB +: CBRP_BRP_W]),
    .i_nom_ts1(nbt[CBRP_TS1_LSB +: CBRP_TS1_W]),
    .i_nom_ts2(nbt[CBRP_TS2_LSB +: CBRP_TS2_W]),
    .i_dat_brp(dbt[CBRP_BRP_LSB +: CBRP_BRP_W]),
    .i_dat_ts1(dbt[CBRP_TS1_LSB +: CBRP_TS1_W]),
    .i_dat_ts2(dbt[CBRP_TS2_LSB +: CBRP_TS2_W]),
    .o_tq_tick(o_tq_tick),
    .o_sample(o_sample),
    .o_bit_end(o_bit_end)
  );

  // ****************************************************************
  // transmit priority
  // ****************************************************************
  // order of the header bits on the bus, lower value wins arbitration
  function automatic logic [CBRP_ARB_W-1:0] arb_key(input logic [CBRP_ID_W-1:0] id,
                                                     input logic ext);
    if (ext) begin
      arb_key = {id[28:18], 1'b1, 1'b1, id[17:0]};
    end else begin
      arb_key = {id[10:0], 1'b0, 1'b0, 18'h00000};
    end
  endfunction : arb_key

  // full sort key: arbitration order, then buffer number; buffer number alone in buffer mode
  function automatic logic [KEY_W-1:0] cand_key(input logic bufmode,
                                                input logic [CBRP_ID_W-1:0] id,
                                                input logic ext,
                                                input logic [BNUM_W-1:0] num);
    if (bufmode) begin
      cand_key = {{CBRP_ARB_W{1'b0}}, num};
    end else begin
      cand_key = {arb_key(id, ext), num};
    end
  endfunction : cand_key

  logic best_valid;
  logic [KEY_W-1:0] best_key;
  logic [1:0] best_kind;
  logic [7:0] best_index;
  logic [BNUM_W-1:0] best_num;
  logic [CBRP_ID_W-1:0] best_id;
  logic best_ext;
  logic [KEY_W-1:0] k;
  logic f_pend;
  logic [CBRP_ID_W-1:0] f_id;
  logic f_ext;

  // search over every candidate; strict less keeps the earliest on ties
  always_comb begin
    k = '0;
    f_pend = 1'b0;
    f_id = '0;
    f_ext = 1'b0;
    best_valid = 1'b0;
    best_key = '1;
    best_kind = CBRP_KIND_BUF;
    best_index = 8'h00;
    best_num = '0;
    best_id = '0;
    best_ext = 1'b0;
    for (int b = 0; b < NBUF; b++) begin
      k = cand_key(prio_bufnum, i_buf_id[b*CBRP_ID_W +: CBRP_ID_W], i_buf_ext[b],
                   BNUM_W'(b));
      if (i_buf_pend[b] && (!best_valid || k < best_key)) begin
        best_valid = 1'b1;
        best_key = k;
        best_kind = CBRP_KIND_BUF;
        best_index = 8'(b);
        best_num = BNUM_W'(b);
        best_id = i_buf_id[b*CBRP_ID_W +: CBRP_ID_W];
        best_ext = i_buf_ext[b];
      end
    end
    for (int f = 0; f < NFIFO; f++) begin
      // head in flight: the entry behind it competes instead
      f_pend = i_fifo_busy[f] ? i_fifo_next_pend[f] : i_fifo_head_pend[f];
      f_id = i_fifo_busy[f] ? i_fifo_next_id[f*CBRP_ID_W +: CBRP_ID_W] :
                              i_fifo_head_id[f*CBRP_ID_W +: CBRP_ID_W];
      f_ext = i_fifo_busy[f] ? i_fifo_next_ext[f] : i_fifo_head_ext[f];
      k = cand_key(prio_bufnum, f_id, f_ext, i_fifo_link[f*BNUM_W +: BNUM_W]);
      if (i_fifo_txmode[f] && f_pend && (!best_valid || k < best_key)) begin
        best_valid = 1'b1;
        best_key = k;
        best_kind = CBRP_KIND_FIFO;
        best_index = 8'(f);
        best_num = i_fifo_link[f*BNUM_W +: BNUM_W];
        best_id = f_id;
        best_ext = f_ext;
      end
    end
    // queues only take part under identifier priority
    for (int q = 0; q < NQ; q++) begin
      k = cand_key(1'b0, i_q_id[q*CBRP_ID_W +: CBRP_ID_W], i_q_ext[q],
                   i_q_num[q*BNUM_W +: BNUM_W]);
      if (!prio_bufnum && i_q_pend[q] && (!best_valid || k < best_key)) begin
        best_valid = 1'b1;
        best_key = k;
        best_kind = CBRP_KIND_QUEUE;
        best_index = 8'(q);
        best_num = i_q_num[q*BNUM_W +: BNUM_W];
        best_id = i_q_id[q*CBRP_ID_W +: CBRP_ID_W];
        best_ext = i_q_ext[q];
      end
    end
  end

  // selection state: winner refreshed every cycle until the frame starts
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      state <= CBRP_SEL;
      o_sel_valid <= 1'b0;
    end else if (cfg_mode) begin
      state <= CBRP_SEL;
      o_sel_valid <= 1'b0;
    end else begin
      case (state)
        CBRP_SEL, CBRP_RDY: begin
          if (state == CBRP_RDY && o_sel_valid && i_tx_start) begin
            state <= CBRP_BUSY;
            o_sel_valid <= 1'b0;
          end else begin
            state <= best_valid ? CBRP_RDY : CBRP_SEL;
            o_sel_valid <= best_valid;
          end
        end
        CBRP_BUSY: begin
          if (i_tx_done || i_arb_lost || i_tx_error) begin
            state <= CBRP_SEL;
          end
        end
        default: begin
          state <= CBRP_SEL;
          o_sel_valid <= 1'b0;
        end
      endcase
    end
  end

  // winner details, frozen while the frame is on the bus
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      o_sel_kind <= CBRP_KIND_BUF;
      o_sel_index <= 8'h00;
      o_sel_num <= '0;
      o_sel_id <= '0;
      o_sel_ext <= 1'b0;
    end else if (state != CBRP_BUSY && !(o_sel_valid && i_tx_start) && best_valid) begin
      o_sel_kind <= best_kind;
      o_sel_index <= best_index;
      o_sel_num <= best_num;
      o_sel_id <= best_id;
      o_sel_ext <= best_ext;
    end
  end

  // helpers for checks: a pending candidate that beats the held winner
  logic buf_beats;
  logic q_beats;
  logic buf_lower;
  always_comb begin
    buf_beats = 1'b0;
    q_beats = 1'b0;
    buf_lower = 1'b0;
    for (int b = 0; b < NBUF; b++) begin
      if (i_buf_pend[b] && cand_key(1'b0, i_buf_id[b*CBRP_ID_W +: CBRP_ID_W], i_buf_ext[b],
          BNUM_W'(b)) < cand_key(1'b0, o_sel_id, o_sel_ext, o_sel_num)) begin
        buf_beats = 1'b1;
      end
      if (i_buf_pend[b] && BNUM_W'(b) < o_sel_num) begin
        buf_lower = 1'b1;
      end
    end
    for (int q = 0; q < NQ; q++) begin
      if (i_q_pend[q] && cand_key(1'b0, i_q_id[q*CBRP_ID_W +: CBRP_ID_W], i_q_ext[q],
          i_q_num[q*BNUM_W +: BNUM_W]) < cand_key(1'b0, o_sel_id, o_sel_ext, o_sel_num)) begin
        q_beats = 1'b1;
      end
    end
  end

  sequence s_retry_event;
    !cfg_mode && state == CBRP_BUSY && (i_arb_lost || i_tx_error);
  endsequence
  sequence s_reselect;
    state == CBRP_SEL && !o_sel_valid;
  endsequence

  a_sel_ready: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (!cfg_mode && state == CBRP_SEL && best_valid && !$rose(cfg_mode)) |=> o_sel_valid)
    else $error("winner not ready one cycle after selection");
  a_retry_reselect: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    s_retry_event |=> s_reselect)
    else $error("no fresh selection after loss or error");
  a_id_order: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    ($rose(o_sel_valid) && !prio_bufnum && $stable(i_buf_pend) && $stable(i_buf_id) &&
     $stable(i_buf_ext)) |-> !buf_beats)
    else $error("a buffer with a winning identifier was passed over");
  a_queue_all: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    ($rose(o_sel_valid) && !prio_bufnum && $stable(i_q_pend) && $stable(i_q_id) &&
     $stable(i_q_ext) && $stable(i_q_num)) |-> !q_beats)
    else $error("a queue entry with a winning identifier was passed over");
  a_bufnum_lowest: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    ($rose(o_sel_valid) && prio_bufnum && $stable(i_buf_pend)) |-> !buf_lower)
    else $error("a lower numbered pending buffer was passed over");
  a_cfg_quiet: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    cfg_mode ##1 cfg_mode |=> (!o_tq_tick && !o_sel_valid))
    else $error("timing or selection active in configuration");
endmodule : cbrp_top

//--- tb/cbrp_tb_engine.sv
`timescale 1ns/1ps
// ****************************************************************
// protocol engine stand-in: takes the winner, then loses arbitration
// ****************************************************************
module cbrp_tb_engine (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset,
  // control and winner
  input wire logic i_en,
  input wire logic i_sel_valid,
  // frame progress
  output logic o_tx_start,
  output logic o_arb_lost
);
  int cnt;
  // start a frame, report arbitration loss four cycles later
  always @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      cnt <= 0;
      o_tx_start <= 1'b0;
      o_arb_lost <= 1'b0;
    end else begin
      o_tx_start <= 1'b0;
      o_arb_lost <= 1'b0;
      if (cnt == 0 && i_en && i_sel_valid && !o_tx_start) begin
        o_tx_start <= 1'b1;
        cnt <= 1;
      end else if (cnt == 4) begin
        o_arb_lost <= 1'b1;
        cnt <= 0;
      end else if (cnt != 0) begin
        cnt <= cnt + 1;
      end
    end
  end
endmodule : cbrp_tb_engine

//--- tb/tb_top.sv
`timescale 1ns/1ps
module tb_top import cbrp_pkg::*;;
  logic i_ref_clk, i_reset, i_psel, i_penable, i_pwrite, i_periph_tick;
  logic i_xosc_tick = 1'b0;
  logic i_data_phase, o_pready, o_pslverr, o_tq_tick, o_sample, o_bit_end, eng_en;
  logic [7:0] i_paddr, o_sel_index;
  logic [31:0] i_pwdata, o_prdata;
  logic [3:0] i_buf_pend, i_buf_ext, i_q_pend, i_q_ext;
  logic [115:0] i_buf_id, i_q_id;
  logic [1:0] i_fifo_txmode, i_fifo_busy, i_fifo_head_pend, i_fifo_head_ext;
  logic [1:0] i_fifo_next_pend, i_fifo_next_ext, o_sel_kind;
  logic [13:0] i_fifo_link;
  logic [57:0] i_fifo_head_id, i_fifo_next_id;
  logic [27:0] i_q_num;
  logic i_tx_start, i_tx_done, i_arb_lost, i_tx_error, o_sel_valid, o_sel_ext;
  logic [6:0] o_sel_num;
  logic [28:0] o_sel_id;
  int mismatches, n_tests;

  // ****************************************************************
  // design, engine stand-in, clock
  // ****************************************************************
  cbrp_top dut (.*);
  cbrp_tb_engine eng (.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_en(eng_en),
    .i_sel_valid(o_sel_valid), .o_tx_start(i_tx_start), .o_arb_lost(i_arb_lost));
  initial begin
    i_ref_clk = 1'b0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end
  // oscillator tick at half the clock rate
  always @(posedge i_ref_clk) i_xosc_tick <= ~i_xosc_tick;

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] exp, input logic eer);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= wr;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_ref_clk);
    i_penable <= 1'b1;
    do @(posedge i_ref_clk); while (o_pready !== 1'b1);
    if (!wr) chk(o_prdata, exp);
    chk(o_pslverr, eer);
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    @(posedge i_ref_clk);
  endtask : apb
  function automatic logic [30:0] akey(input logic [28:0] id, input logic ext);
    return ext ? {id[28:18], 2'b11, id[17:0]} : {id[10:0], 20'h00000};
  endfunction : akey
  // one bit: cycles, quanta and sample quantum between two bit ends
  task automatic bit_meas(input int ecyc);
    int cyc, tqs, smp;
    cyc = 0;
    tqs = 0;
    smp = 0;
    repeat (2) do @(posedge i_ref_clk); while (o_bit_end !== 1'b1 && ++cyc < 500);
    cyc = 0;
    do begin
      @(posedge i_ref_clk);
      cyc++;
      if (o_tq_tick === 1'b1) tqs++;
      if (o_sample === 1'b1) smp = tqs;
    end while (o_bit_end !== 1'b1 && cyc < 500);
    chk(cyc, ecyc);
    chk(tqs, 8);
    chk(smp, 5);
  endtask : bit_meas
  task automatic sel_chk(input logic [1:0] k, input logic [6:0] n, input logic [28:0] id);
    repeat (3) @(posedge i_ref_clk);
    chk(o_sel_valid, 1'b1);
    chk(o_sel_kind, k);
    chk(o_sel_num, n);
    chk(o_sel_id, id);
  endtask : sel_chk
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (30000) @(posedge i_ref_clk);
    mismatches++;
    report_and_stop();
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    logic [30:0] bk;
    logic [6:0] bn;
    logic [28:0] bid;
    logic [1:0] bkd;
    logic any;
    logic bex;
    int bix;
    {i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} = '0;
    {i_data_phase, i_tx_done, i_tx_error, eng_en} = '0;
    {i_buf_pend, i_buf_ext, i_q_pend, i_q_ext, i_buf_id, i_q_id} = '0;
    {i_fifo_txmode, i_fifo_busy, i_fifo_head_pend, i_fifo_head_ext} = '0;
    {i_fifo_next_pend, i_fifo_next_ext, i_fifo_link, i_fifo_head_id, i_fifo_next_id} = '0;
    i_q_num = {7'h0B, 7'h0A, 7'h09, 7'h08};
    i_periph_tick = 1'b1;
    i_reset = 1'b1;
    mismatches = 0;
    n_tests = 0;
    void'($urandom(83));
    repeat (16) @(posedge i_ref_clk);
    i_reset <= 1'b0;
    @(posedge i_ref_clk);
    apb(0, CBRP_OFS_GCFG, 0, CBRP_GCFG_RST, 0);
    apb(0, CBRP_OFS_CTRL, 0, CBRP_CTRL_RST, 0);
    apb(0, CBRP_OFS_NBT, 0, CBRP_NBT_RST, 0);
    apb(0, CBRP_OFS_DBT, 0, CBRP_DBT_RST, 0);
    apb(0, CBRP_OFS_STAT, 0, 32'h1, 0);
    apb(0, 8'h14, 0, 32'h0, 1);
    apb(1, CBRP_OFS_STAT, 32'h1, 0, 1);
    apb(1, CBRP_OFS_CTRL, 32'h0, 0, 0);
    apb(1, CBRP_OFS_NBT, 32'h020C1001, 0, 1);
    bit_meas(32);
    i_data_phase <= 1'b1;
    bit_meas(8);
    apb(1, CBRP_OFS_CTRL, 32'h1, 0, 0);
    apb(1, CBRP_OFS_GCFG, 32'h2, 0, 0);
    apb(1, CBRP_OFS_CTRL, 32'h0, 0, 0);
    bit_meas(16);
    i_data_phase <= 1'b0;
    // random buffers and queue entries under identifier priority
    repeat (24) begin
      i_buf_pend <= 4'($urandom);
      i_q_pend <= 4'($urandom);
      i_buf_ext <= 4'($urandom);
      i_q_ext <= 4'($urandom);
      for (int b = 0; b < 4; b++) i_buf_id[b*29+:29] <= 29'($urandom);
      for (int b = 0; b < 4; b++) i_q_id[b*29+:29] <= 29'($urandom);
      @(posedge i_ref_clk);
      any = 0;
      {bk, bn, bid, bkd} = '0;
      for (int b = 0; b < 8; b++) begin
        if (b < 4 ? i_buf_pend[b] : i_q_pend[b-4]) begin
          if (!any || akey(b < 4 ? i_buf_id[b*29+:29] : i_q_id[(b-4)*29+:29],
                           b < 4 ? i_buf_ext[b] : i_q_ext[b-4]) < bk) begin
            bk = akey(b < 4 ? i_buf_id[b*29+:29] : i_q_id[(b-4)*29+:29],
                      b < 4 ? i_buf_ext[b] : i_q_ext[b-4]);
            bn = b < 4 ? 7'(b) : i_q_num[(b-4)*7+:7];
            bid = b < 4 ? i_buf_id[b*29+:29] : i_q_id[(b-4)*29+:29];
            bkd = b < 4 ? CBRP_KIND_BUF : CBRP_KIND_QUEUE;
            bex = b < 4 ? i_buf_ext[b] : i_q_ext[b-4];
            bix = b < 4 ? b : b - 4;
          end
          any = 1;
        end
      end
      if (any) begin
        sel_chk(bkd, bn, bid);
        chk(o_sel_ext, bex);
        chk(o_sel_index, bix);
      end else begin
        @(posedge i_ref_clk);
        chk(o_sel_valid, 1'b0);
      end
    end
    i_buf_id <= {4{29'h155}};
    i_buf_ext <= 4'h0;
    i_q_ext <= 4'h0;
    i_buf_pend <= 4'b0110;
    i_q_pend <= 4'h0;
    sel_chk(CBRP_KIND_BUF, 7'h01, 29'h155);
    i_q_id <= {29'h120, 29'h130, 29'h140, 29'h150};
    i_q_pend <= 4'hF;
    sel_chk(CBRP_KIND_QUEUE, 7'h0B, 29'h120);
    i_q_pend <= 4'h0;
    i_fifo_txmode <= 2'b01;
    i_fifo_link <= 14'h0005;
    i_fifo_head_pend <= 2'b01;
    i_fifo_next_pend <= 2'b01;
    i_fifo_head_id <= 58'h10;
    i_fifo_next_id <= 58'h20;
    i_fifo_busy <= 2'b01;
    sel_chk(CBRP_KIND_FIFO, 7'h05, 29'h020);
    i_fifo_busy <= 2'b00;
    sel_chk(CBRP_KIND_FIFO, 7'h05, 29'h010);
    i_fifo_head_pend <= 2'b00;
    i_fifo_next_pend <= 2'b00;
    eng_en <= 1'b1;
    do @(posedge i_ref_clk); while (i_tx_start !== 1'b1);
    i_buf_id[3*29+:29] <= 29'h001;
    i_buf_pend[3] <= 1'b1;
    do @(posedge i_ref_clk); while (i_arb_lost !== 1'b1);
    eng_en <= 1'b0;
    sel_chk(CBRP_KIND_BUF, 7'h03, 29'h001);
    // buffer-number priority, queues left idle
    apb(1, CBRP_OFS_CTRL, 32'h1, 0, 0);
    apb(1, CBRP_OFS_GCFG, 32'h1, 0, 0);
    apb(1, CBRP_OFS_CTRL, 32'h0, 0, 0);
    i_buf_pend <= 4'b1010;
    i_fifo_link <= 14'h0000;
    i_fifo_head_pend <= 2'b01;
    i_fifo_head_id <= 58'h7FF;
    sel_chk(CBRP_KIND_FIFO, 7'h00, 29'h7FF);
    i_fifo_head_pend <= 2'b00;
    sel_chk(CBRP_KIND_BUF, 7'h01, 29'h155);
    report_and_stop();
  end
endmodule : tb_top
